// *** rtl/cam_pkg.sv ***
// Package with the addressing-mode encodings, opcode fields and constants.
package cam_pkg;

	// Addressing modes selected by an opcode.
	typedef enum logic [2:0] {
		CAM_INH,     // Inherent, opcode byte only.
		CAM_IMM,     // Immediate data byte.
		CAM_DIR,     // Direct page address byte.
		CAM_EXT,     // Full 16-bit address, high byte first.
		CAM_IX,      // Index register only.
		CAM_IX1,     // Index plus 8-bit offset.
		CAM_IX2,     // Index plus 16-bit offset.
		CAM_REL      // Signed branch offset.
	} cam_mode_e;

	// Instruction lengths in bytes, opcode included.
	localparam logic [1:0] CAM_LEN_ONE   = 2'h1;
	localparam logic [1:0] CAM_LEN_TWO   = 2'h2;
	localparam logic [1:0] CAM_LEN_THREE = 2'h3;

	// Opcode row (high nibble) values that choose the mode.
	localparam logic [3:0] CAM_ROW_BITBR = 4'h0;
	localparam logic [3:0] CAM_ROW_BITOP = 4'h1;
	localparam logic [3:0] CAM_ROW_REL   = 4'h2;
	localparam logic [3:0] CAM_ROW_DIRM  = 4'h3;
	localparam logic [3:0] CAM_ROW_INHA  = 4'h4;
	localparam logic [3:0] CAM_ROW_INHX  = 4'h5;
	localparam logic [3:0] CAM_ROW_IX1M  = 4'h6;
	localparam logic [3:0] CAM_ROW_IXM   = 4'h7;
	localparam logic [3:0] CAM_ROW_CTL1  = 4'h8;
	localparam logic [3:0] CAM_ROW_CTL2  = 4'h9;
	localparam logic [3:0] CAM_ROW_IMM   = 4'ha;
	localparam logic [3:0] CAM_ROW_DIR   = 4'hb;
	localparam logic [3:0] CAM_ROW_EXT   = 4'hc;
	localparam logic [3:0] CAM_ROW_IX2   = 4'hd;
	localparam logic [3:0] CAM_ROW_IX1   = 4'he;
	localparam logic [3:0] CAM_ROW_IX    = 4'hf;

	// Opcodes that break the row pattern.
	localparam logic [7:0] CAM_OPC_MUL   = 8'h42; // The unsigned_multiply_op opcode.
	localparam logic [7:0] CAM_OPC_BSR   = 8'had; // Branch to subroutine, relative.

	// High address byte forced for page-zero modes.
	localparam logic [7:0] CAM_PAGE_ZERO = 8'h00;

	// Reset values of the result registers.
	localparam logic [15:0] CAM_ADDR_RST = 16'h0000;
	localparam logic [7:0]  CAM_BYTE_RST = 8'h00;

endpackage : cam_pkg

// *** rtl/cam_address_mode_unit.sv ***
// Addressing-mode decoder, effective-address former and multiply result placement.
`timescale 1ns/1ns

// Operation
// - Each of 256 opcodes picks one mode.
// - Inherent: one byte, no operand address.
// - Immediate: two bytes, data used directly.
// - Direct: two bytes, high address byte zero.
// - Extended: three bytes, high then low.
// - Indexed no offset: one byte, page zero.
// - Indexed 8-bit: index plus byte, unsigned.
// - Indexed 16-bit: high, low, plus index.
// - Taken branch: next address plus signed offset.
// - Untaken branch continues after the branch.
// - Multiply: high to index, low to accumulator.
module cam_address_mode_unit (
	input  wire logic              CLK_I,        // CPU clock.
	input  wire logic              RST_N_I,      // Synchronous reset, active low.
	input  wire logic              OPC_VALID_I,  // Opcode byte offered.
	input  wire logic [7:0]        OPC_I,        // Opcode byte.
	output logic                   OPC_READY_O,  // Unit can take an opcode.
	input  wire logic              BYTE_VALID_I, // Operand byte offered.
	input  wire logic [7:0]        BYTE_I,       // Operand byte.
	output logic                   BYTE_READY_O, // Unit waits for an operand byte.
	input  wire logic [7:0]        INDEX_I,      // Index register.
	input  wire logic [7:0]        ACC_I,        // Accumulator.
	input  wire logic [15:0]       NEXT_PC_I,    // Address after the instruction.
	input  wire logic              BR_COND_I,    // Branch condition is true.
	output cam_pkg::cam_mode_e     MODE_O,       // Mode of the last opcode.
	output logic [1:0]             LENGTH_O,     // Length of the last opcode.
	output logic                   DONE_O,       // Instruction fully decoded.
	output logic                   EA_VALID_O,   // Operand address formed.
	output logic [15:0]            EA_O,         // Operand address.
	output logic                   IMM_VALID_O,  // Immediate data ready.
	output logic [7:0]             IMM_O,        // Immediate data.
	output logic                   PC_LOAD_O,    // Branch taken, load target.
	output logic [15:0]            PC_TARGET_O,  // Branch destination.
	output logic                   MUL_VALID_O,  // Product ready.
	output logic [7:0]             MUL_X_O,      // Product high byte for index.
	output logic [7:0]             MUL_A_O       // Product low byte for accumulator.
);
	import cam_pkg::*;

	// Sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE,   // Waiting for an opcode.
		ST_BYTE1,  // Waiting for the first operand byte.
		ST_BYTE2   // Waiting for the second operand byte.
	} cam_state_e;

	// Maps an opcode to its addressing mode.
	function automatic cam_mode_e mode_of(input logic [7:0] opc);
		cam_mode_e m;
		m = CAM_INH;
		unique case (opc[7:4])
			CAM_ROW_BITBR, CAM_ROW_REL: begin
				m = CAM_REL;
			end
			CAM_ROW_BITOP, CAM_ROW_DIRM, CAM_ROW_DIR: begin
				m = CAM_DIR;
			end
			CAM_ROW_INHA, CAM_ROW_INHX, CAM_ROW_CTL1, CAM_ROW_CTL2: begin
				m = CAM_INH;
			end
			CAM_ROW_IX1M, CAM_ROW_IX1: begin
				m = CAM_IX1;
			end
			CAM_ROW_IXM, CAM_ROW_IX: begin
				m = CAM_IX;
			end
			CAM_ROW_IMM: begin
				// The subroutine branch sits in the immediate row.
				m = (opc == CAM_OPC_BSR) ? CAM_REL : CAM_IMM;
			end
			CAM_ROW_EXT: begin
				m = CAM_EXT;
			end
			CAM_ROW_IX2: begin
				m = CAM_IX2;
			end
		endcase
		return m;
	endfunction : mode_of

	// Returns the byte count of a mode; bit-test branches add one.
	function automatic logic [1:0] length_of(input cam_mode_e m, input logic bitbr);
		logic [1:0] n;
		n = CAM_LEN_ONE;
		unique case (m)
			CAM_INH, CAM_IX: begin
				n = CAM_LEN_ONE;
			end
			CAM_IMM, CAM_DIR, CAM_IX1: begin
				n = CAM_LEN_TWO;
			end
			CAM_EXT, CAM_IX2: begin
				n = CAM_LEN_THREE;
			end
			CAM_REL: begin
				n = bitbr ? CAM_LEN_THREE : CAM_LEN_TWO;
			end
		endcase
		return n;
	endfunction : length_of

	cam_state_e   state_reg;     // Sequencer state.
	cam_mode_e    mode_reg;      // Mode of the instruction in flight.
	logic [1:0]   len_reg;       // Length of the instruction in flight.
	logic         bitbr_reg;     // Instruction is a bit-test branch.
	logic [7:0]   first_reg;     // First operand byte.
	cam_mode_e    opc_mode;      // Mode of the offered opcode.
	logic         opc_bitbr;     // Offered opcode is a bit-test branch.
	logic         opc_take;      // Opcode accepted this cycle.
	logic         byte_take;     // Operand byte accepted this cycle.
	logic [8:0]   ix1_sum;       // Nine-bit index plus offset sum.
	logic [15:0]  rel_target;    // Next address plus signed offset.
	logic [15:0]  ix2_sum;       // Sixteen-bit offset plus index.
	logic [15:0]  product;       // Accumulator times index.

	// Handshakes and decode of the offered opcode.
	assign OPC_READY_O  = (state_reg == ST_IDLE);
	assign BYTE_READY_O = (state_reg != ST_IDLE);
	assign opc_take     = OPC_VALID_I && OPC_READY_O;
	assign byte_take    = BYTE_VALID_I && BYTE_READY_O;
	assign opc_mode     = mode_of(OPC_I);
	assign opc_bitbr    = (OPC_I[7:4] == CAM_ROW_BITBR);

	// Address arithmetic; carries above the result width are dropped.
	assign ix1_sum    = {1'b0, INDEX_I} + {1'b0, BYTE_I};
	assign rel_target = NEXT_PC_I + {{8{BYTE_I[7]}}, BYTE_I};
	assign ix2_sum    = {first_reg, BYTE_I} + {CAM_PAGE_ZERO, INDEX_I};
	assign product    = ACC_I * INDEX_I;

	// Sequencer: counts operand bytes according to the mode length.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			state_reg <= ST_IDLE;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					// One-byte instructions finish in the opcode cycle.
					if (opc_take && length_of(opc_mode, opc_bitbr) != CAM_LEN_ONE) begin
						state_reg <= ST_BYTE1;
					end
				end
				ST_BYTE1: begin
					if (byte_take) begin
						state_reg <= (len_reg == CAM_LEN_THREE) ? ST_BYTE2 : ST_IDLE;
					end
				end
				ST_BYTE2: begin
					if (byte_take) begin
						state_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Latches the decoded mode and length of each accepted opcode.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			mode_reg  <= CAM_INH;
			len_reg   <= CAM_LEN_ONE;
			bitbr_reg <= 1'b0;
		end else if (opc_take) begin
			mode_reg  <= opc_mode;
			len_reg   <= length_of(opc_mode, opc_bitbr);
			bitbr_reg <= opc_bitbr;
		end
	end

	// Holds the first operand byte of three-byte instructions.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			first_reg <= CAM_BYTE_RST;
		end else if (byte_take && state_reg == ST_BYTE1) begin
			first_reg <= BYTE_I;
		end
	end

	// Effective-address former for all memory-referencing modes.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			EA_VALID_O <= 1'b0;
			EA_O       <= CAM_ADDR_RST;
		end else begin
			EA_VALID_O <= 1'b0;
			if (opc_take && opc_mode == CAM_IX) begin
				// Index register alone addresses page zero.
				EA_VALID_O <= 1'b1;
				EA_O       <= {CAM_PAGE_ZERO, INDEX_I};
			end else if (byte_take && state_reg == ST_BYTE1) begin
				unique case (mode_reg)
					CAM_DIR: begin
						EA_VALID_O <= 1'b1;
						EA_O       <= {CAM_PAGE_ZERO, BYTE_I};
					end
					CAM_IX1: begin
						EA_VALID_O <= 1'b1;
						EA_O       <= {7'h00, ix1_sum};
					end
					CAM_REL: begin
						// A bit-test branch first names its tested byte.
						EA_VALID_O <= bitbr_reg;
						EA_O       <= {CAM_PAGE_ZERO, BYTE_I};
					end
					default: begin
						// Immediate and wide modes form nothing yet.
						EA_VALID_O <= 1'b0;
					end
				endcase
			end else if (byte_take && state_reg == ST_BYTE2) begin
				if (mode_reg == CAM_EXT) begin
					EA_VALID_O <= 1'b1;
					EA_O       <= {first_reg, BYTE_I};
				end else if (mode_reg == CAM_IX2) begin
					EA_VALID_O <= 1'b1;
					EA_O       <= ix2_sum;
				end
			end
		end
	end

	// Immediate data path; the byte never becomes an address.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			IMM_VALID_O <= 1'b0;
			IMM_O       <= CAM_BYTE_RST;
		end else begin
			IMM_VALID_O <= byte_take && state_reg == ST_BYTE1 && mode_reg == CAM_IMM;
			if (byte_take && state_reg == ST_BYTE1 && mode_reg == CAM_IMM) begin
				IMM_O <= BYTE_I;
			end
		end
	end

	// Branch resolution on the offset byte, which is the last byte.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			PC_LOAD_O   <= 1'b0;
			PC_TARGET_O <= CAM_ADDR_RST;
		end else begin
			PC_LOAD_O <= 1'b0;
			if (byte_take && mode_reg == CAM_REL &&
					(state_reg == ST_BYTE2 || !bitbr_reg)) begin
				// A false condition leaves the fetcher on the next address.
				PC_LOAD_O   <= BR_COND_I;
				PC_TARGET_O <= BR_COND_I ? rel_target : NEXT_PC_I;
			end
		end
	end

	// Completion pulse and the reported mode and length.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			DONE_O   <= 1'b0;
			MODE_O   <= CAM_INH;
			LENGTH_O <= CAM_LEN_ONE;
		end else begin
			DONE_O <= (opc_take && length_of(opc_mode, opc_bitbr) == CAM_LEN_ONE) ||
				(byte_take && (state_reg == ST_BYTE2 ||
				(state_reg == ST_BYTE1 && len_reg == CAM_LEN_TWO)));
			if (opc_take) begin
				MODE_O   <= opc_mode;
				LENGTH_O <= length_of(opc_mode, opc_bitbr);
			end
		end
	end

	// Unsigned multiply result split between index and accumulator.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			MUL_VALID_O <= 1'b0;
			MUL_X_O     <= CAM_BYTE_RST;
			MUL_A_O     <= CAM_BYTE_RST;
		end else begin
			MUL_VALID_O <= opc_take && OPC_I == CAM_OPC_MUL;
			if (opc_take && OPC_I == CAM_OPC_MUL) begin
				MUL_X_O <= product[15:8];
				MUL_A_O <= product[7:0];
			end
		end
	end

	// Inherent opcodes never produce an address.
	a_inherent_no_ea: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		opc_take && opc_mode == CAM_INH |=> !EA_VALID_O && DONE_O)
		else $error("Inherent opcode produced an address.");

	// Immediate data appears unchanged one cycle after its byte.
	a_immediate_data: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		byte_take && state_reg == ST_BYTE1 && mode_reg == CAM_IMM
		|=> IMM_VALID_O && IMM_O == $past(BYTE_I) && !EA_VALID_O)
		else $error("Immediate byte not passed through.");

	// Direct address lies in page zero.
	a_direct_page: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		byte_take && state_reg == ST_BYTE1 && mode_reg == CAM_DIR
		|=> EA_VALID_O && EA_O == {8'h00, $past(BYTE_I)})
		else $error("Direct address not in page zero.");

	// Extended address pairs the two bytes high first.
	a_extended_order: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		opc_take && opc_mode == CAM_EXT ##1 byte_take ##1 byte_take
		|=> EA_VALID_O && EA_O == {$past(BYTE_I, 2), $past(BYTE_I)} && DONE_O)
		else $error("Extended address bytes misordered.");

	// Index alone addresses page zero at once.
	a_index_page: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		opc_take && opc_mode == CAM_IX
		|=> EA_VALID_O && EA_O == {8'h00, $past(INDEX_I)} && OPC_READY_O)
		else $error("Indexed address wrong.");

	// Eight-bit offset sum keeps its ninth bit.
	a_ix1_sum: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		byte_take && state_reg == ST_BYTE1 && mode_reg == CAM_IX1
		|=> EA_O == 16'($past(INDEX_I)) + 16'($past(BYTE_I)) && EA_O <= 16'h01fe)
		else $error("Eight-bit offset address wrong.");

	// Sixteen-bit offset adds the index and wraps.
	a_ix2_sum: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		byte_take && state_reg == ST_BYTE2 && mode_reg == CAM_IX2
		|=> EA_O == 16'({first_reg, $past(BYTE_I)} + 16'($past(INDEX_I))))
		else $error("Sixteen-bit offset address wrong.");

	// Taken branch goes to next address plus signed offset.
	a_branch_taken: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		PC_LOAD_O |-> PC_TARGET_O == 16'($past(NEXT_PC_I) + {{8{$past(BYTE_I[7])}},
		$past(BYTE_I)}))
		else $error("Branch target wrong.");

	// Untaken branch never loads the counter.
	a_branch_skip: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		byte_take && mode_reg == CAM_REL && !BR_COND_I |=> !PC_LOAD_O)
		else $error("Untaken branch loaded the counter.");

	// Product halves land in index and accumulator.
	a_mul_split: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		opc_take && OPC_I == CAM_OPC_MUL
		|=> MUL_VALID_O && {MUL_X_O, MUL_A_O} == $past(ACC_I) * $past(INDEX_I))
		else $error("Multiply result misplaced.");

endmodule : cam_address_mode_unit

// *** tb/cam_fetch_model.sv ***
// Fetch sequencer model that offers opcode and operand bytes to the unit.
`timescale 1ns/1ns
module cam_fetch_model (
	input  wire logic       clk_i,        // CPU clock.
	input  wire logic       opc_ready_i,  // Unit takes an opcode.
	input  wire logic       byte_ready_i, // Unit takes an operand byte.
	output logic            opc_valid_o,  // Opcode offered.
	output logic [7:0]      opc_o,        // Opcode byte.
	output logic            byte_valid_o, // Operand byte offered.
	output logic [7:0]      byte_o        // Operand byte.
);
	// Idle lines start low.
	initial begin
		opc_valid_o = 1'b0;
		opc_o = 8'h00;
		byte_valid_o = 1'b0;
		byte_o = 8'h00;
	end

	// Sends one instruction; entered just after a rising edge, returns likewise.
	task automatic send(input logic [7:0] opc, input logic [15:0] opnd, input int nb,
		input int stall);
		logic [7:0] b;
		opc_valid_o = 1'b1;
		opc_o = opc;
		do @(negedge clk_i); while (opc_ready_i !== 1'b1);
		@(posedge clk_i);
		#1;
		opc_valid_o = 1'b0;
		opc_o = ~opc;
		for (int i = 0; i < nb; i++) begin
			b = (nb == 2 && i == 0) ? opnd[15:8] : opnd[7:0]; // High byte first.
			// A slow fetch leaves the released byte line toggling.
			repeat (stall) begin
				@(posedge clk_i);
				#1;
				byte_o = ~byte_o;
			end
			byte_valid_o = 1'b1;
			byte_o = b;
			do @(negedge clk_i); while (byte_ready_i !== 1'b1);
			@(posedge clk_i);
			#1;
			// Back-to-back bytes keep the valid line up instead of pulsing it.
			if (i == nb - 1 || stall > 0) begin
				byte_valid_o = 1'b0;
				byte_o = ~b;
			end
		end
	endtask : send
endmodule : cam_fetch_model

// *** tb/tb_top.sv ***
// Self-checking testbench for the addressing-mode unit.
`timescale 1ns/1ns
module tb_top;
	import cam_pkg::*;
	logic        clk = 1'b0;       // CPU clock.
	logic        rst_n = 1'b0;     // Reset, active low.
	logic        opc_valid;        // Opcode offered.
	logic [7:0]  opc;              // Opcode byte.
	logic        byte_valid;       // Operand offered.
	logic [7:0]  opnd;             // Operand byte.
	logic [7:0]  index = 8'h00;    // Index register.
	logic [7:0]  acc = 8'h00;      // Accumulator.
	logic [15:0] next_pc = 16'h0000; // Address after a branch.
	logic        cond = 1'b0;      // Branch condition.
	logic        opc_rdy, byte_rdy, done, ea_v, imm_v, pc_ld, mul_v;
	cam_mode_e   mode;
	logic [1:0]  len;
	logic [15:0] ea, pc_tgt;
	logic [7:0]  imm, mul_x, mul_a;
	int          n_errors = 0;     // Mismatches seen.
	int          cmp_count = 0;    // Comparisons made.

	// The clock toggles every half period of 5 ns.
	always #5 clk = ~clk;

	cam_fetch_model fm_u (.clk_i(clk), .opc_ready_i(opc_rdy), .byte_ready_i(byte_rdy),
		.opc_valid_o(opc_valid), .opc_o(opc), .byte_valid_o(byte_valid), .byte_o(opnd));

	cam_address_mode_unit dut_u (.CLK_I(clk), .RST_N_I(rst_n), .OPC_VALID_I(opc_valid),
		.OPC_I(opc), .OPC_READY_O(opc_rdy), .BYTE_VALID_I(byte_valid), .BYTE_I(opnd),
		.BYTE_READY_O(byte_rdy), .INDEX_I(index), .ACC_I(acc), .NEXT_PC_I(next_pc),
		.BR_COND_I(cond), .MODE_O(mode), .LENGTH_O(len), .DONE_O(done), .EA_VALID_O(ea_v),
		.EA_O(ea), .IMM_VALID_O(imm_v), .IMM_O(imm), .PC_LOAD_O(pc_ld),
		.PC_TARGET_O(pc_tgt), .MUL_VALID_O(mul_v), .MUL_X_O(mul_x), .MUL_A_O(mul_a));

	// Counts a comparison and reports a mismatch.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Prints the verdict and ends the run.
	task automatic report_and_stop;
		if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop

	// Runs one instruction and stops at the cycle where its result pulses stand.
	task automatic run(input logic [7:0] o, input logic [15:0] b, input int nb,
		input int stall, input logic [7:0] x, input logic [7:0] a, input logic [15:0] pc,
		input logic c);
		int k;
		@(posedge clk);
		#1;
		index = x;
		acc = a;
		next_pc = pc;
		cond = c;
		fm_u.send(o, b, nb, stall);
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (done !== 1'b1 && k < 4);
	endtask : run

	// Judges mode, length and pulses {ea, imm, pc load, mul}, then that pulses last one cycle.
	task automatic expect_res(input cam_mode_e m, input logic [1:0] l, input logic [3:0] p);
		check(done, 1'b1);
		check(mode, m);
		check(len, l);
		check({ea_v, imm_v, pc_ld, mul_v}, p);
		check({opc_rdy, byte_rdy}, 2'b10);
		@(negedge clk);
		check({done, ea_v, imm_v, pc_ld, mul_v}, 5'h00);
	endtask : expect_res

	// Reset state of every output.
	task automatic t_reset;
		check({opc_rdy, byte_rdy, done, ea_v, imm_v, pc_ld, mul_v}, 7'h40);
		check({mode, len}, {CAM_INH, CAM_LEN_ONE});
		check({ea, pc_tgt}, {CAM_ADDR_RST, CAM_ADDR_RST});
		check({imm, mul_x, mul_a}, {CAM_BYTE_RST, CAM_BYTE_RST, CAM_BYTE_RST});
	endtask : t_reset

	// Every opcode row picks its mode and length.
	task automatic t_rows;
		cam_mode_e  mt [16] = '{CAM_REL, CAM_DIR, CAM_REL, CAM_DIR, CAM_INH, CAM_INH,
			CAM_IX1, CAM_IX, CAM_INH, CAM_INH, CAM_IMM, CAM_DIR, CAM_EXT, CAM_IX2,
			CAM_IX1, CAM_IX};
		logic [1:0] lt [16] = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1,
			2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
		for (int r = 0; r < 16; r++) begin
			run({r[3:0], 4'h6}, 16'h0101, int'(lt[r]) - 1, 0, 8'h00, 8'h00, 16'h0000, 1'b0);
			check(mode, mt[r]);
			check(len, lt[r]);
		end
		run(CAM_OPC_BSR, 16'h0000, 1, 0, 8'h00, 8'h00, 16'h0000, 1'b0);
		check(mode, CAM_REL);
	endtask : t_rows

	// Operand forms that build or skip an address.
	task automatic t_address;
		run(8'h4c, 16'h0000, 0, 0, 8'h33, 8'h00, 16'h0000, 1'b0);
		expect_res(CAM_INH, CAM_LEN_ONE, 4'b0000);
		run(8'ha6, 16'h005a, 1, 1, 8'h00, 8'h00, 16'h0000, 1'b0);
		check(imm, 8'h5a);
		expect_res(CAM_IMM, CAM_LEN_TWO, 4'b0100);
		run(8'hb6, 16'h00fe, 1, 2, 8'h77, 8'h00, 16'h0000, 1'b0);
		check(ea, 16'h00fe);
		expect_res(CAM_DIR, CAM_LEN_TWO, 4'b1000);
		run(8'hc6, 16'h1234, 2, 1, 8'h00, 8'h00, 16'h0000, 1'b0);
		check(ea, 16'h1234);
		expect_res(CAM_EXT, CAM_LEN_THREE, 4'b1000);
		run(8'hf6, 16'h0000, 0, 0, 8'ha5, 8'h00, 16'h0000, 1'b0);
		check(ea, 16'h00a5);
		expect_res(CAM_IX, CAM_LEN_ONE, 4'b1000);
		run(8'he6, 16'h00ff, 1, 0, 8'hff, 8'h00, 16'h0000, 1'b0);
		check(ea, 16'h01fe);
		expect_res(CAM_IX1, CAM_LEN_TWO, 4'b1000);
		run(8'hd6, 16'h1234, 2, 0, 8'h10, 8'h00, 16'h0000, 1'b0);
		check(ea, 16'h1244);
		run(8'hd6, 16'hffff, 2, 2, 8'h02, 8'h00, 16'h0000, 1'b0);
		check(ea, 16'h0001);
		expect_res(CAM_IX2, CAM_LEN_THREE, 4'b1000);
	endtask : t_address

	// Taken and untaken branches, both reach limits and a wrap.
	task automatic t_branch;
		logic [7:0]  ot [4] = '{8'h7f, 8'h80, 8'h05, 8'hf0};
		logic        ct [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
		logic [15:0] pt [4] = '{16'h0100, 16'h0100, 16'h0100, 16'h0005};
		logic [15:0] et [4] = '{16'h017f, 16'h0080, 16'h0100, 16'hfff5};
		for (int i = 0; i < 4; i++) begin
			run(8'h26, {8'h00, ot[i]}, 1, i, 8'h00, 8'h00, pt[i], ct[i]);
			check(pc_tgt, et[i]);
			expect_res(CAM_REL, CAM_LEN_TWO, {2'b00, ct[i], 1'b0});
		end
		// Bit-test branch: tested byte in page zero, then a taken offset.
		run(8'h00, 16'h4005, 2, 0, 8'h00, 8'h00, 16'h0200, 1'b1);
		check(ea, 16'h0040);
		check(pc_tgt, 16'h0205);
		expect_res(CAM_REL, CAM_LEN_THREE, 4'b0010);
	endtask : t_branch

	// Product halves go to index and accumulator.
	task automatic t_multiply;
		run(CAM_OPC_MUL, 16'h0000, 0, 0, 8'hff, 8'hff, 16'h0000, 1'b0);
		check({mul_x, mul_a}, 16'hfe01);
		expect_res(CAM_INH, CAM_LEN_ONE, 4'b0001);
		run(CAM_OPC_MUL, 16'h0000, 0, 0, 8'h0c, 8'h15, 16'h0000, 1'b0);
		check({mul_x, mul_a}, 16'h00fc);
	endtask : t_multiply

	// Watchdog sized well above the roughly 140 cycles the tests need.
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end

	// Main sequence: reset for 16 cycles, then each scenario.
	initial begin
		repeat (16) @(posedge clk);
		#1;
		rst_n = 1'b1;
		@(negedge clk);
		t_reset();
		t_rows();
		t_address();
		t_branch();
		t_multiply();
		report_and_stop();
	end
endmodule : tb_top
